// ---- exec_model.sv ----
// Executor model that issues operand requests one cycle at a time
`timescale 1ns/10ps
module exec_model (
    input wire logic clk,
    input wire opr_pkg::op_rsp_t rsp,
    output opr_pkg::op_req_t req
);
    import opr_pkg::*;
    initial req = '0;
    // Request is held up to the taking edge; the one-cycle answer is read just after it
    // Callers head every group on a decade boundary, except the X group read at 8
    task automatic xfer(input op_req_t r, output op_rsp_t s);
        req = r;
        @(posedge clk);
        #1;
        s = rsp;
    endtask
    task automatic idle();
        req.valid = 1'b0;
        @(posedge clk);
        #1;
    endtask
endmodule // exec_model

// ---- opr_params.svh ----
// Device map, grouping and pairing constants for the operand resolver
`ifndef OPR_PARAMS_SVH
`define OPR_PARAMS_SVH
`define X_MAIN_SM_HI 16'h0003
`define X_MAIN_LG_HI 16'h0007
`define X_EXT_LO 8
`define X_EXT_HI 55
`define X_EXT_HI_N 16'h0037
`define X_TERM_LO 250
`define X_TERM_HI 255
`define X_TERM_LG_N 16'h00FA
`define X_TERM_SM_N 16'h00FD
`define X_TERM_HI_N 16'h00FF
`define Y_BITS 56
`define Y_SM_HI 16'h0005
`define Y_LG_HI 16'h0037
`define M_BITS 688
`define M_GEN_N 16'h0200
`define M_RET_LO 16'h0064
`define M_SPC_LO 16'h2328
`define M_SPC_HI 16'h23D7
`define M_SPC_SHIFT 16'h2128
`define D_WORDS 7600
`define D_SM_HI 16'h07CF
`define D_LG_HI 16'h0F9F
`define D_RET_LO 16'h0064
`define D_FILE_LO 16'h0FA0
`define D_FILE_HI 16'h1B57
`define D_SPC_LO 16'h2328
`define D_SM_SPC_HI 16'h2461
`define D_LG_SPC_HI 16'h257F
`define D_SPC_SHIFT 16'h07D0
`define P_SM_HI 16'h007F
`define P_LG_HI 16'h00FF
`define IDX_HI 16'h0007
`define GRP_MAX16 4'h4
`define GRP_MAX32 4'h8
`define GEN_DECL_LO 8'h01
`define GEN_DECL_HI 8'h04
`endif

// ---- opr_pkg.sv ----
// Types shared by the operand resolver and its executor
package opr_pkg;
    typedef enum logic [2:0] {
        DK_X = 3'h0, DK_Y = 3'h1, DK_M = 3'h2, DK_P = 3'h3,
        DK_D = 3'h4, DK_V = 3'h5, DK_Z = 3'h6
    } dev_kind_t;
    typedef struct packed {
        logic valid;
        logic write;
        dev_kind_t kind;
        logic wide;
        logic [3:0] groups;
        logic indexed;
        logic idx_long;
        logic [2:0] idx_sel;
        logic jump;
        logic [15:0] num;
        logic [31:0] wdata;
    } op_req_t;
    typedef struct packed {
        logic done;
        logic err;
        logic retained;
        logic [15:0] eff;
        logic [31:0] rdata;
    } op_rsp_t;
    typedef struct packed {
        logic [5:0] term;
        logic [47:0] ext;
        logic [7:0] main;
    } in_pins_t;
endpackage

// ---- opr_resolver.sv ----
// Operand resolver: device map, nibble groups, word pairing, index offsets
`timescale 1ns/10ps
`include "opr_params.svh"
module opr_resolver (
    input wire logic clk,
    input wire logic arst_n,
    input wire opr_pkg::op_req_t req,
    input wire opr_pkg::in_pins_t pins,
    input wire logic model_large,
    input wire logic [7:0] claim_mask,
    input wire logic [7:0] gen_in_decl,
    input wire logic [11:0] file_reg_count,
    output opr_pkg::op_rsp_t rsp,
    output logic [`Y_BITS-1:0] y_pins
);
    import opr_pkg::*;

    logic rst_m_q, rst_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_m_q <= 1'b0;
            rst_q <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_q <= rst_m_q;
        end
    end

    in_pins_t pin_m_q, pin_q;
    logic lg_m_q, lg_s_q;
    always_ff @(posedge clk or negedge rst_q) begin
        if (!rst_q) begin
            pin_m_q <= '0;
            pin_q <= '0;
            lg_m_q <= 1'b0;
            lg_s_q <= 1'b0;
        end else begin
            pin_m_q <= pins;
            pin_q <= pin_m_q;
            lg_m_q <= model_large;
            lg_s_q <= lg_m_q;
        end
    end

    // Model strap is frozen once the synchroniser has settled after release
    logic [1:0] st_q;
    logic large_q;
    always_ff @(posedge clk or negedge rst_q) begin
        if (!rst_q) begin
            st_q <= 2'h0;
            large_q <= 1'b0;
        end else if (st_q != 2'h3) begin
            st_q <= st_q + 2'h1;
            if (st_q == 2'h2) large_q <= lg_s_q;
        end
    end

    function automatic logic dev_ok(input dev_kind_t k, input logic [15:0] n, input logic lg,
                                    input logic [11:0] fc);
        logic [15:0] fo;
        fo = 16'(n - `D_FILE_LO);
        case (k)
            DK_X: dev_ok = n <= (lg ? `X_MAIN_LG_HI : `X_MAIN_SM_HI) || (lg && n <= `X_EXT_HI_N) ||
                           (n >= (lg ? `X_TERM_LG_N : `X_TERM_SM_N) && n <= `X_TERM_HI_N);
            DK_Y: dev_ok = n <= (lg ? `Y_LG_HI : `Y_SM_HI);
            DK_M: dev_ok = n < `M_GEN_N || (n >= `M_SPC_LO && n <= `M_SPC_HI);
            DK_P: dev_ok = n <= (lg ? `P_LG_HI : `P_SM_HI);
            DK_D: dev_ok = n <= (lg ? `D_LG_HI : `D_SM_HI) ||
                           (n >= `D_FILE_LO && n <= `D_FILE_HI && fo < {4'h0, fc}) ||
                           (n >= `D_SPC_LO && n <= (lg ? `D_LG_SPC_HI : `D_SM_SPC_HI));
            DK_V, DK_Z: dev_ok = n <= `IDX_HI;
            default: dev_ok = 1'b0;
        endcase
    endfunction

    function automatic logic keeps(input dev_kind_t k, input logic [15:0] n, input logic lg);
        keeps = (k == DK_D && n >= `D_FILE_LO && n <= `D_FILE_HI) ||
                (lg && k == DK_D && n >= `D_RET_LO && n <= `D_LG_HI) ||
                (lg && k == DK_M && n >= `M_RET_LO && n < `M_GEN_N);
    endfunction

    function automatic logic [9:0] m_slot(input logic [15:0] n);
        m_slot = (n >= `M_SPC_LO) ? 10'(n - `M_SPC_SHIFT) : n[9:0];
    endfunction

    function automatic logic [12:0] d_slot(input logic [15:0] n);
        d_slot = (n >= `D_SPC_LO) ? 13'(n - `D_SPC_SHIFT) : n[12:0];
    endfunction

    logic decl_ok;
    logic [255:0] x_img;
    always_comb begin
        decl_ok = gen_in_decl >= `GEN_DECL_LO && gen_in_decl <= `GEN_DECL_HI;
        x_img = '0;
        x_img[7:0] = pin_q.main & ~claim_mask;
        if (!large_q) x_img[7:4] = 4'h0;
        if (large_q) x_img[`X_EXT_HI:`X_EXT_LO] = pin_q.ext;
        if (decl_ok) x_img[`X_TERM_HI:`X_TERM_LO] = large_q ? pin_q.term : {pin_q.term[5:3], 3'h0};
    end

    logic [`Y_BITS-1:0] y_q;
    logic [`M_BITS-1:0] m_q;
    logic [15:0] d_mem [0:`D_WORDS-1];
    logic [15:0] v_q [0:7];
    logic [31:0] z_q [0:7];

    logic [15:0] off, eff, last;
    logic [5:0] nbits;
    logic [31:0] nmask, grp_rd, wd, rdata_c;
    logic [9:0] mh;
    logic [12:0] ds, ds1;
    logic ok, is_bit, is_vz, wr_go;
    always_comb begin
        off = req.idx_long ? z_q[req.idx_sel][15:0] : v_q[req.idx_sel];
        eff = (req.indexed && !req.jump) ? 16'(req.num + off) : req.num;
        nbits = (req.groups == 4'h0) ? 6'h01 : {req.groups, 2'b00};
        nmask = (nbits >= 6'h20) ? 32'hFFFFFFFF : 32'((33'h1 << nbits) - 33'h1);
        last = 16'(eff + {10'h0, nbits} - 16'h0001);
        is_bit = req.kind == DK_X || req.kind == DK_Y || req.kind == DK_M;
        is_vz = req.kind == DK_V || req.kind == DK_Z;
        ok = !(req.indexed && is_vz) &&
             !(req.groups != 4'h0 && !is_bit) &&
             req.groups <= (req.wide ? `GRP_MAX32 : `GRP_MAX16) &&
             dev_ok(req.kind, eff, large_q, file_reg_count) &&
             dev_ok(req.kind, last, large_q, file_reg_count) &&
             !(req.write && (req.kind == DK_X || req.kind == DK_P)) &&
             !(req.kind == DK_D && req.wide &&
               (eff[0] || !dev_ok(DK_D, 16'(eff + 16'h0001), large_q, file_reg_count)));
        mh = m_slot(eff);
        ds = d_slot(eff);
        ds1 = 13'(ds + 13'h0001);
        case (req.kind)
            DK_X: grp_rd = 32'(x_img >> eff[7:0]);
            DK_Y: grp_rd = 32'(y_q >> eff[5:0]);
            default: grp_rd = 32'(m_q >> mh);
        endcase
        grp_rd = grp_rd & nmask;
        wd = (req.wide ? req.wdata : {16'h0000, req.wdata[15:0]}) & (is_bit ? nmask : 32'hFFFFFFFF);
        wr_go = req.valid && req.write && ok;
        case (req.kind)
            DK_X, DK_Y, DK_M: rdata_c = grp_rd;
            DK_P: rdata_c = {16'h0000, eff};
            DK_D: rdata_c = {req.wide ? d_mem[ds1] : 16'h0000, d_mem[ds]};
            DK_V: rdata_c = {16'h0000, v_q[eff[2:0]]};
            DK_Z: rdata_c = z_q[eff[2:0]];
            default: rdata_c = 32'h00000000;
        endcase
        if (!req.wide) rdata_c[31:16] = 16'h0000;
        if (!req.valid || req.write || !ok) rdata_c = 32'h00000000;
    end

    // Group writes touch only the bits they cover, so words can sit side by side
    always_ff @(posedge clk or negedge rst_q) begin
        if (!rst_q) begin
            y_q <= '0;
        end else if (wr_go && req.kind == DK_Y) begin
            y_q <= (y_q & ~(`Y_BITS'(nmask) << eff[5:0])) | (`Y_BITS'(wd) << eff[5:0]);
        end
    end

    always_ff @(posedge clk or negedge rst_q) begin
        if (!rst_q) begin
            m_q <= '0;
        end else if (wr_go && req.kind == DK_M) begin
            m_q <= (m_q & ~(`M_BITS'(nmask) << mh)) | (`M_BITS'(wd) << mh);
        end
    end

    // Cell storage has no reset so it can map onto block memory
    always_ff @(posedge clk) begin
        if (wr_go && req.kind == DK_D) begin
            d_mem[ds] <= wd[15:0];
            if (req.wide) d_mem[ds1] <= wd[31:16];
        end
    end

    always_ff @(posedge clk or negedge rst_q) begin
        if (!rst_q) begin
            v_q <= '{default: 16'h0000};
            z_q <= '{default: 32'h00000000};
        end else if (wr_go && req.kind == DK_V) begin
            v_q[eff[2:0]] <= wd[15:0];
        end else if (wr_go && req.kind == DK_Z) begin
            z_q[eff[2:0]] <= wd;
        end
    end

    op_rsp_t rsp_q;
    always_ff @(posedge clk or negedge rst_q) begin
        if (!rst_q) begin
            rsp_q <= '0;
        end else begin
            rsp_q.done <= req.valid;
            rsp_q.err <= req.valid && !ok;
            rsp_q.retained <= req.valid && ok && keeps(req.kind, eff, large_q);
            rsp_q.eff <= eff;
            rsp_q.rdata <= rdata_c;
        end
    end

    assign rsp = rsp_q;
    assign y_pins = y_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_q);

    idx_sum_a: assert property (req.valid && req.indexed && !req.jump |=>
        rsp_q.eff == 16'($past(req.num) + $past(off))) else $error("indexed number not offset");
    jump_plain_a: assert property (req.valid && req.jump |=>
        rsp_q.eff == $past(req.num)) else $error("jump label was offset");
    grp_limit_a: assert property (req.valid && !req.wide && req.groups > `GRP_MAX16 |=>
        rsp_q.done && rsp_q.err) else $error("oversize group accepted");
    zero_fill_a: assert property (req.valid && !req.write && is_bit && req.groups != 4'h0 && ok |=>
        (rsp_q.rdata >> $past(nbits)) == 32'h00000000) else $error("bits above group not zero");
    reidx_rej_a: assert property (req.valid && req.indexed && is_vz |=>
        rsp_q.err) else $error("offset register was indexed");
    term_gate_a: assert property (!decl_ok |->
        x_img[`X_TERM_HI:`X_TERM_LO] == 6'h00) else $error("terminal readable without declaration");
    claim_hide_a: assert property ((x_img[7:0] & claim_mask) == 8'h00)
        else $error("claimed input visible");
    y_overflow_a: assert property (wr_go && req.kind == DK_Y && req.groups == 4'h1 && eff == 16'h0000 |=>
        y_q[`Y_BITS-1:4] == $past(y_q[`Y_BITS-1:4])) else $error("group write spilled");
    file_ret_a: assert property (req.valid && ok && req.kind == DK_D && eff >= `D_FILE_LO && eff <= `D_FILE_HI
        |=> rsp_q.retained) else $error("file register not retained");
    file_size_a: assert property (req.valid && req.kind == DK_D && eff >= `D_FILE_LO && eff <= `D_FILE_HI &&
        16'(eff - `D_FILE_LO) >= {4'h0, file_reg_count} |=> rsp_q.err) else $error("file beyond count");
endmodule // opr_resolver

// ---- tb.sv ----
// Self-checking bench for the operand resolver
`timescale 1ns/10ps
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin num_errors++; \
    $display("unexpected %s exp %0h got %0h", n, e, a); end end
module tb;
    import opr_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic model_large = 1'b1;
    op_req_t req;
    op_rsp_t rsp;
    op_rsp_t s;
    in_pins_t pins = '0;
    logic [7:0] claim_mask = 8'h00;
    logic [7:0] gen_in_decl = 8'h01;
    logic [11:0] file_reg_count = 12'hBB8;
    logic [55:0] y_pins;
    int num_errors = 0;
    int comparisons = 0;
    initial forever #4 clk = ~clk;
    opr_resolver dut_u (.clk(clk), .arst_n(arst_n), .req(req), .pins(pins), .model_large(model_large),
        .claim_mask(claim_mask), .gen_in_decl(gen_in_decl), .file_reg_count(file_reg_count),
        .rsp(rsp), .y_pins(y_pins));
    exec_model exec_u (.clk(clk), .rsp(rsp), .req(req));
    function automatic op_req_t mk(logic w, dev_kind_t k, logic wd, logic [3:0] g, logic [15:0] n,
        logic [31:0] d);
        return op_req_t'{valid: 1'b1, write: w, kind: k, wide: wd, groups: g, num: n, wdata: d,
            default: '0};
    endfunction
    function automatic op_req_t ix(op_req_t r, logic l, logic [2:0] sel);
        r.indexed = 1'b1;
        r.idx_long = l;
        r.idx_sel = sel;
        return r;
    endfunction
    task automatic go(input op_req_t r, input logic e);
        exec_u.xfer(r, s);
        `CHK("done", 1'b1, s.done)
        `CHK("err", e, s.err)
    endtask
    task automatic t_groups();
        go(mk(1, DK_Y, 0, 1, 16'h0000, 32'h0000FFFF), 0);
        `CHK("y_pins", 56'hF, y_pins)
        go(mk(0, DK_Y, 0, 2, 16'h0000, 0), 0);
        `CHK("rdata", 32'hF, s.rdata)
        go(mk(1, DK_M, 1, 3, 16'h000A, 32'hFFFFFFFF), 0);
        go(mk(0, DK_M, 1, 8, 16'h0000, 0), 0);
        `CHK("rdata", 32'h003FFC00, s.rdata)
        go(mk(0, DK_M, 0, 1, 16'h0014, 0), 0);
        `CHK("rdata", 32'h3, s.rdata)
        go(mk(0, DK_M, 0, 5, 16'h0000, 0), 1);
        go(mk(0, DK_M, 1, 9, 16'h0000, 0), 1);
        go(mk(0, DK_D, 0, 1, 16'h0000, 0), 1);
        exec_u.idle();
        $display("test groups done");
    endtask
    task automatic t_pair();
        go(mk(1, DK_D, 1, 0, 16'h0064, 32'h12345678), 0);
        go(mk(0, DK_D, 0, 0, 16'h0065, 0), 0);
        `CHK("rdata", 32'h1234, s.rdata)
        `CHK("retained", 1'b1, s.retained)
        go(mk(0, DK_D, 1, 0, 16'h0065, 0), 1);
        go(mk(0, DK_D, 0, 0, 16'h0032, 0), 0);
        `CHK("retained", 1'b0, s.retained)
        exec_u.idle();
        $display("test pair done");
    endtask
    task automatic t_index();
        go(mk(1, DK_V, 0, 0, 16'h0001, 32'h8), 0);
        go(mk(1, DK_Z, 1, 0, 16'h0002, 32'h0001000A), 0);
        go(mk(0, DK_Z, 1, 0, 16'h0002, 0), 0);
        `CHK("rdata", 32'h0001000A, s.rdata)
        go(mk(1, DK_D, 0, 0, 16'h000C, 32'hABCD), 0);
        go(ix(mk(0, DK_D, 0, 0, 16'h0004, 0), 0, 1), 0);
        `CHK("rdata", 32'hABCD, s.rdata)
        `CHK("eff", 16'h000C, s.eff)
        go(ix(mk(0, DK_D, 1, 0, 16'h0002, 0), 1, 2), 0);
        `CHK("eff", 16'h000C, s.eff)
        go(ix(mk(0, DK_D, 1, 0, 16'h0004, 0), 0, 1), 0);
        `CHK("eff", 16'h000C, s.eff)
        go(ix(mk(0, DK_P, 0, 0, 16'h0005, 0), 0, 1), 0);
        `CHK("eff", 16'h000D, s.eff)
        go(ix(op_req_t'{valid: 1, kind: DK_P, jump: 1, num: 16'h0005, default: '0}, 0, 1), 0);
        `CHK("eff", 16'h0005, s.eff)
        go(ix(mk(0, DK_V, 0, 0, 16'h0000, 0), 0, 1), 1);
        exec_u.idle();
        $display("test index done");
    endtask
    task automatic t_map();
        go(mk(1, DK_X, 0, 0, 16'h0000, 1), 1);
        go(mk(0, DK_P, 0, 0, 16'h00FF, 0), 0);
        go(mk(0, DK_P, 0, 0, 16'h0100, 0), 1);
        go(mk(0, DK_D, 0, 0, 16'h257F, 0), 0);
        go(mk(0, DK_D, 0, 0, 16'h2580, 0), 1);
        go(mk(0, DK_M, 0, 0, 16'h23D7, 0), 0);
        go(mk(0, DK_M, 0, 0, 16'h23D8, 0), 1);
        go(mk(0, DK_Y, 0, 0, 16'h0038, 0), 1);
        file_reg_count = 12'h00A;
        go(mk(0, DK_D, 0, 0, 16'h0FA9, 0), 0);
        go(mk(0, DK_D, 0, 0, 16'h0FAA, 0), 1);
        pins = '{term: 6'h3F, ext: 48'h1, main: 8'hA5};
        claim_mask = 8'h01;
        repeat (3) @(posedge clk);
        #1;
        go(mk(0, DK_X, 0, 2, 16'h0000, 0), 0);
        `CHK("rdata", 32'hA4, s.rdata)
        go(mk(0, DK_X, 0, 1, 16'h0008, 0), 0);
        `CHK("rdata", 32'h1, s.rdata)
        go(mk(0, DK_X, 0, 0, 16'h00FA, 0), 0);
        `CHK("rdata", 32'h1, s.rdata)
        gen_in_decl = 8'h00;
        go(mk(0, DK_X, 0, 0, 16'h00FA, 0), 0);
        `CHK("rdata", 32'h0, s.rdata)
        exec_u.idle();
        $display("test map done");
    endtask
    // Small model needs a fresh reset, since the strap is frozen after release
    task automatic t_small();
        arst_n = 1'b0;
        model_large = 1'b0;
        gen_in_decl = 8'h04;
        repeat (3) @(posedge clk);
        #1;
        arst_n = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        go(mk(0, DK_X, 0, 1, 16'h0000, 0), 0);
        `CHK("rdata", 32'h4, s.rdata)
        go(mk(0, DK_X, 0, 0, 16'h0004, 0), 1);
        go(mk(0, DK_X, 0, 0, 16'h00FD, 0), 0);
        `CHK("rdata", 32'h1, s.rdata)
        go(mk(0, DK_X, 0, 0, 16'h00FC, 0), 1);
        go(mk(0, DK_Y, 0, 0, 16'h0005, 0), 0);
        go(mk(0, DK_Y, 0, 0, 16'h0006, 0), 1);
        go(mk(0, DK_P, 0, 0, 16'h007F, 0), 0);
        go(mk(0, DK_P, 0, 0, 16'h0080, 0), 1);
        go(mk(0, DK_D, 0, 0, 16'h07CF, 0), 0);
        go(mk(0, DK_D, 0, 0, 16'h07D0, 0), 1);
        go(mk(0, DK_D, 0, 0, 16'h2461, 0), 0);
        go(mk(0, DK_D, 0, 0, 16'h2462, 0), 1);
        go(mk(0, DK_M, 0, 0, 16'h01FF, 0), 0);
        `CHK("retained", 1'b0, s.retained)
        go(mk(0, DK_M, 0, 0, 16'h0200, 0), 1);
        go(mk(0, DK_D, 0, 0, 16'h0FA0, 0), 0);
        `CHK("retained", 1'b1, s.retained)
        exec_u.idle();
        $display("test small done");
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        #1;
        arst_n = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        t_groups();
        t_pair();
        t_index();
        t_map();
        t_small();
        stop_test();
    end
endmodule // tb
